// ===== include/sadcs_pkg.sv
// Purpose: shared constants for the serial converter sequencer
// Assumes: APB with 32-bit data, one word per register
// Notes: variant codes select channel count and readout form
package sadcs_pkg;
	// register byte offsets
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_RESULT = 12'h008;
	localparam logic [11:0] OFS_MUX = 12'h00C;
	// variant field of the control register
	localparam int CTRL_VAR_LSB = 0;
	localparam logic [1:0] VAR_ONE = 2'h0;
	localparam logic [1:0] VAR_FOUR = 2'h1;
	localparam logic [1:0] VAR_EIGHT = 2'h2;
	localparam logic [1:0] CTRL_RST = 2'h2;
	// status fields
	localparam int STAT_ACTIVE_BIT = 0;
	localparam int STAT_OE_BIT = 1;
	localparam int STAT_STATE_LSB = 4;
	// assignment word length per variant
	localparam logic [2:0] NBITS_ONE = 3'h0;
	localparam logic [2:0] NBITS_FOUR = 3'h3;
	localparam logic [2:0] NBITS_EIGHT = 3'h4;
	// result width and readout counts
	localparam int RES_BITS = 8;
	localparam logic [3:0] CONV_STEPS = 4'h8;
	localparam logic [3:0] LSB_SHIFTS = 4'h7;
	localparam logic [7:0] SAR_TOP = 8'h80;
	localparam logic [31:0] RESULT_RST = 32'h00000000;
	// sequencer states
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_SAMPLE, ST_CONV, ST_FIN, ST_LSB, ST_TAIL} sadcs_st_e;
endpackage

// ===== rtl/sadcs_sar.sv
// Purpose: successive approximation register, one decision per step
// Assumes: comparator answer is valid when step is pulsed
// Notes: code_q is the trial code; after the last step it is the result
`timescale 1ns/1ps
module sadcs_sar (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_start,
	input wire logic i_step,
	input wire logic i_cmp_hi,
	output logic [7:0] o_code
);
	logic [7:0] code_q;
	logic [7:0] code_d;
	logic [7:0] mask_q;
	logic [7:0] mask_d;

	// keep or drop the trial bit, then try the next lower one
	always_comb begin
		code_d = code_q;
		mask_d = mask_q;
		if (i_start) begin
			code_d = sadcs_pkg::SAR_TOP;
			mask_d = sadcs_pkg::SAR_TOP;
		end else if (i_step) begin
			code_d = (i_cmp_hi ? code_q : (code_q & ~mask_q)) | (mask_q >> 1);
			mask_d = mask_q >> 1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			code_q <= 8'h00;
			mask_q <= 8'h00;
		end else begin
			code_q <= code_d;
			mask_q <= mask_d;
		end
	end

	assign o_code = code_q;
endmodule

// ===== rtl/sadcs_top.sv
// Purpose: serial link sequencer of an 8-bit successive approximation converter
// Assumes: serial clock and link pins synchronous to I_MCLK and much slower
// Notes: serial clock edges are seen in the same master cycle, decoded straight from the pin
`timescale 1ns/1ps
module sadcs_top (
	input wire logic I_MCLK,
	input wire logic I_RST_B,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [11:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	input wire logic I_CS_B,
	input wire logic I_SCLK,
	input wire logic I_SERIAL_IN_LINE,
	input wire logic I_LSB_FIRST_SHIFT_ENABLE,
	input wire logic I_CMP_HI,
	output logic O_DO,
	output logic O_DO_OE,
	output logic O_CONVERSION_ACTIVE_FLAG,
	output logic [7:0] O_DAC_CODE,
	output logic [2:0] O_CH_POS,
	output logic [2:0] O_CH_NEG,
	output logic O_NEG_IS_COM
);
	logic rst_s1_q;
	logic rst_n;
	logic sclk_q;
	logic rise;
	logic fall;
	sadcs_pkg::sadcs_st_e st_q;
	sadcs_pkg::sadcs_st_e st_d;
	logic [3:0] addr_q;
	logic [3:0] addr_d;
	logic [2:0] acnt_q;
	logic [2:0] acnt_d;
	logic [3:0] step_q;
	logic [3:0] step_d;
	logic [7:0] shr_q;
	logic [7:0] shr_d;
	logic do_q;
	logic do_d;
	logic oe_q;
	logic oe_d;
	logic active_q;
	logic active_d;
	logic [7:0] result_q;
	logic [7:0] result_d;
	logic [2:0] pos_q;
	logic [2:0] pos_d;
	logic [2:0] neg_q;
	logic [2:0] neg_d;
	logic com_q;
	logic com_d;
	logic sar_start;
	logic sar_step;
	logic [7:0] sar_code;
	logic [1:0] ctrl_q;
	logic [1:0] ctrl_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic pready_q;
	logic pready_d;
	logic pslverr_q;
	logic pslverr_d;
	logic var_one;
	logic var_eight;
	logic [2:0] nbits;
	logic hold_lsb;

	// reset release through two flops
	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			rst_s1_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n <= rst_s1_q;
		end
	end

	// serial clock edges, taken as synchronous
	always_ff @(posedge I_MCLK or negedge rst_n) begin
		if (!rst_n) begin
			sclk_q <= 1'b0;
		end else begin
			sclk_q <= I_SCLK;
		end
	end
	assign rise = I_SCLK & ~sclk_q;
	assign fall = ~I_SCLK & sclk_q;

	// variant decode; an unused code behaves as four channels
	assign var_one = (ctrl_q == sadcs_pkg::VAR_ONE);
	assign var_eight = (ctrl_q == sadcs_pkg::VAR_EIGHT);
	assign nbits = var_one ? sadcs_pkg::NBITS_ONE :
		(var_eight ? sadcs_pkg::NBITS_EIGHT : sadcs_pkg::NBITS_FOUR);
	assign hold_lsb = var_eight & I_LSB_FIRST_SHIFT_ENABLE;

	sadcs_sar u_sar (
		.i_clk(I_MCLK),
		.i_rst_n(rst_n),
		.i_start(sar_start),
		.i_step(sar_step),
		.i_cmp_hi(I_CMP_HI),
		.o_code(sar_code)
	);

	// link sequencer next state
	always_comb begin
		logic single_end;
		logic odd;
		logic [1:0] sel;
		single_end = 1'b0;
		odd = 1'b0;
		sel = 2'h0;
		st_d = st_q;
		addr_d = addr_q;
		acnt_d = acnt_q;
		step_d = step_q;
		shr_d = shr_q;
		do_d = do_q;
		oe_d = oe_q;
		active_d = active_q;
		result_d = result_q;
		pos_d = pos_q;
		neg_d = neg_q;
		com_d = com_q;
		sar_start = 1'b0;
		sar_step = 1'b0;
		// word order: mode flag, polarity, select MSB first
		if (var_eight) begin
			single_end = addr_q[3];
			odd = addr_q[2];
			sel = addr_q[1:0];
		end else begin
			single_end = addr_q[2];
			odd = addr_q[1];
			sel = {1'b0, addr_q[0]};
		end
		if (I_CS_B) begin
			// deselect clears the link side; a fresh select fall restarts
			st_d = sadcs_pkg::ST_IDLE;
			addr_d = 4'h0;
			acnt_d = 3'h0;
			step_d = 4'h0;
			shr_d = 8'h00;
			do_d = 1'b0;
			oe_d = 1'b0;
			active_d = 1'b0;
		end else begin
			unique case (st_q)
				sadcs_pkg::ST_IDLE: begin
					// zeros before the first one are dropped
					if (rise && I_SERIAL_IN_LINE) begin
						st_d = (nbits == 3'h0) ? sadcs_pkg::ST_SAMPLE : sadcs_pkg::ST_ADDR;
					end
				end
				sadcs_pkg::ST_ADDR: begin
					if (rise) begin
						addr_d = {addr_q[2:0], I_SERIAL_IN_LINE};
						acnt_d = acnt_q + 3'h1;
						if (acnt_q + 3'h1 == nbits) begin
							st_d = sadcs_pkg::ST_SAMPLE;
						end
					end
				end
				sadcs_pkg::ST_SAMPLE: begin
					// the falling edge closes the half period sampling gap
					if (fall) begin
						st_d = sadcs_pkg::ST_CONV;
						active_d = 1'b1;
						oe_d = 1'b1;
						do_d = 1'b0;
						sar_start = 1'b1;
						if (var_one) begin
							pos_d = 3'h0;
							neg_d = 3'h1;
							com_d = 1'b0;
						end else begin
							pos_d = {sel, odd};
							neg_d = single_end ? 3'h0 : {sel, ~odd};
							com_d = single_end;
						end
					end
				end
				sadcs_pkg::ST_CONV: begin
					if (fall) begin
						sar_step = 1'b1;
						do_d = I_CMP_HI;
						step_d = step_q + 4'h1;
						if (step_q + 4'h1 == sadcs_pkg::CONV_STEPS) begin
							st_d = sadcs_pkg::ST_FIN;
						end
					end
				end
				sadcs_pkg::ST_FIN: begin
					// flag drops on the rising edge after the last decision
					if (rise) begin
						active_d = 1'b0;
						shr_d = sar_code;
						result_d = sar_code;
						step_d = 4'h0;
						st_d = var_one ? sadcs_pkg::ST_TAIL : sadcs_pkg::ST_LSB;
					end
				end
				sadcs_pkg::ST_LSB: begin
					// LSB already on the line; shift the remaining seven
					if (fall && !hold_lsb) begin
						shr_d = shr_q >> 1;
						do_d = shr_q[1];
						step_d = step_q + 4'h1;
						if (step_q + 4'h1 == sadcs_pkg::LSB_SHIFTS) begin
							st_d = sadcs_pkg::ST_TAIL;
						end
					end
				end
				sadcs_pkg::ST_TAIL: begin
					if (fall) begin
						do_d = 1'b0;
					end
				end
				default: begin
					st_d = sadcs_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge I_MCLK or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= sadcs_pkg::ST_IDLE;
			addr_q <= 4'h0;
			acnt_q <= 3'h0;
			step_q <= 4'h0;
			shr_q <= 8'h00;
			do_q <= 1'b0;
			oe_q <= 1'b0;
			active_q <= 1'b0;
			result_q <= 8'h00;
			pos_q <= 3'h0;
			neg_q <= 3'h0;
			com_q <= 1'b0;
		end else begin
			st_q <= st_d;
			addr_q <= addr_d;
			acnt_q <= acnt_d;
			step_q <= step_d;
			shr_q <= shr_d;
			do_q <= do_d;
			oe_q <= oe_d;
			active_q <= active_d;
			result_q <= result_d;
			pos_q <= pos_d;
			neg_q <= neg_d;
			com_q <= com_d;
		end
	end

	// apb slave: no wait states, ready is set from the setup phase, and every output comes from a flop
	always_comb begin
		ctrl_d = ctrl_q;
		prdata_d = 32'h00000000;
		pslverr_d = 1'b0;
		pready_d = I_PSEL & ~I_PENABLE & ~pready_q;
		if (I_PSEL && !I_PENABLE && !pready_q) begin
			unique case (I_PADDR)
				sadcs_pkg::OFS_CTRL: prdata_d[sadcs_pkg::CTRL_VAR_LSB +: 2] = ctrl_q;
				sadcs_pkg::OFS_STATUS: begin
					prdata_d[sadcs_pkg::STAT_ACTIVE_BIT] = active_q;
					prdata_d[sadcs_pkg::STAT_OE_BIT] = oe_q;
					prdata_d[sadcs_pkg::STAT_STATE_LSB +: 3] = st_q;
				end
				sadcs_pkg::OFS_RESULT: prdata_d[7:0] = result_q;
				sadcs_pkg::OFS_MUX: prdata_d[3:0] = addr_q;
				default: pslverr_d = 1'b1;
			endcase
		end
		// write lands at the completing edge only
		if (I_PSEL && I_PENABLE && pready_q && I_PWRITE && !pslverr_q && I_PADDR == sadcs_pkg::OFS_CTRL) begin
			ctrl_d = I_PWDATA[sadcs_pkg::CTRL_VAR_LSB +: 2];
		end
	end

	always_ff @(posedge I_MCLK or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= sadcs_pkg::CTRL_RST;
			prdata_q <= sadcs_pkg::RESULT_RST;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// output pins, all straight from flops
	assign O_PRDATA = prdata_q;
	assign O_PREADY = pready_q;
	assign O_PSLVERR = pslverr_q;
	assign O_DO = do_q;
	assign O_DO_OE = oe_q;
	assign O_CONVERSION_ACTIVE_FLAG = active_q;
	assign O_DAC_CODE = sar_code;
	assign O_CH_POS = pos_q;
	assign O_CH_NEG = neg_q;
	assign O_NEG_IS_COM = com_q;

	// checks on the link sequencer
	property p_start;
		@(posedge I_MCLK) disable iff (!rst_n)
		(st_q == sadcs_pkg::ST_IDLE && !I_CS_B && rise && I_SERIAL_IN_LINE) |=> (st_q != sadcs_pkg::ST_IDLE);
	endproperty
	a_start: assert property (p_start) else $error("start bit not taken");

	property p_zero_ignored;
		@(posedge I_MCLK) disable iff (!rst_n)
		(st_q == sadcs_pkg::ST_IDLE && rise && !I_SERIAL_IN_LINE) |=> (st_q == sadcs_pkg::ST_IDLE);
	endproperty
	a_zero_ignored: assert property (p_zero_ignored) else $error("leading zero left idle");

	property p_flag_rise;
		@(posedge I_MCLK) disable iff (!rst_n)
		$rose(O_CONVERSION_ACTIVE_FLAG) |-> ($past(st_q) == sadcs_pkg::ST_SAMPLE && $past(fall) && O_DO_OE);
	endproperty
	a_flag_rise: assert property (p_flag_rise) else $error("active flag rose off the sampling edge");

	property p_lead_zero;
		@(posedge I_MCLK) disable iff (!rst_n)
		$rose(O_DO_OE) |-> !O_DO;
	endproperty
	a_lead_zero: assert property (p_lead_zero) else $error("no leading zero");

	property p_decision;
		@(posedge I_MCLK) disable iff (!rst_n)
		(st_q == sadcs_pkg::ST_CONV && !I_CS_B && fall) |=> (O_DO == $past(I_CMP_HI));
	endproperty
	a_decision: assert property (p_decision) else $error("decision not on output");

	property p_flag_fall;
		@(posedge I_MCLK) disable iff (!rst_n)
		$fell(O_CONVERSION_ACTIVE_FLAG) && !I_CS_B |-> ($past(step_q) == sadcs_pkg::CONV_STEPS && $past(rise));
	endproperty
	a_flag_fall: assert property (p_flag_fall) else $error("flag fell before eight decisions");

	property p_hold_lsb;
		@(posedge I_MCLK) disable iff (!rst_n)
		(st_q == sadcs_pkg::ST_LSB && hold_lsb && !I_CS_B) |=> $stable(O_DO);
	endproperty
	a_hold_lsb: assert property (p_hold_lsb) else $error("lsb not held");

	property p_tail_low;
		@(posedge I_MCLK) disable iff (!rst_n)
		(st_q == sadcs_pkg::ST_TAIL && fall) |=> !O_DO;
	endproperty
	a_tail_low: assert property (p_tail_low) else $error("output not low after readout");

	property p_single_msb;
		@(posedge I_MCLK) disable iff (!rst_n)
		(st_q == sadcs_pkg::ST_FIN && var_one && rise && !I_CS_B) |=> (st_q == sadcs_pkg::ST_TAIL);
	endproperty
	a_single_msb: assert property (p_single_msb) else $error("single variant repeated lsb first");

	property p_clear;
		@(posedge I_MCLK) disable iff (!rst_n)
		I_CS_B |=> (st_q == sadcs_pkg::ST_IDLE && !O_DO_OE && !O_CONVERSION_ACTIVE_FLAG);
	endproperty
	a_clear: assert property (p_clear) else $error("deselect did not clear");

	property p_float_addr;
		@(posedge I_MCLK) disable iff (!rst_n)
		(st_q == sadcs_pkg::ST_IDLE || st_q == sadcs_pkg::ST_ADDR || st_q == sadcs_pkg::ST_SAMPLE) |-> !O_DO_OE;
	endproperty
	a_float_addr: assert property (p_float_addr) else $error("output driven while addressing");

	c_conv_done: cover property (@(posedge I_MCLK) disable iff (!rst_n) $fell(O_CONVERSION_ACTIVE_FLAG));
	c_lsb_hold: cover property (@(posedge I_MCLK) disable iff (!rst_n) st_q == sadcs_pkg::ST_LSB && hold_lsb);
	c_tail: cover property (@(posedge I_MCLK) disable iff (!rst_n) st_q == sadcs_pkg::ST_TAIL && !var_one);
endmodule

// ===== tb/sadcs_host.sv
// Purpose: host side of the serial link, drives select, serial clock and data in
// Assumes: half serial period of four master cycles
// Notes: data in toggles once released, so a sampler that keeps looking shows up
`timescale 1ns/1ps
module sadcs_host (
	input wire logic i_clk,
	input wire logic i_go,
	input wire logic [15:0] i_bits,
	input wire logic [4:0] i_nb,
	input wire logic [4:0] i_nx,
	input wire logic i_do,
	input wire logic i_flag,
	output logic o_cs_b,
	output logic o_sclk,
	output logic o_serial_in,
	output logic o_busy,
	output logic [31:0] o_rx,
	output logic [31:0] o_fl
);
	int k;
	// idle: deselected, serial clock parked low
	initial begin
		o_cs_b = 1'b1;
		o_sclk = 1'b0;
		o_serial_in = 1'b0;
		o_busy = 1'b0;
		o_rx = 32'h0;
		o_fl = 32'h0;
	end
	// one frame per go request, captures data out and flag at each rise after the input bits
	always @(posedge i_clk) begin
		if (i_go && !o_busy) begin
			o_busy <= 1'b1;
			o_rx <= 32'h0;
			o_fl <= 32'h0;
			o_cs_b <= 1'b0;
			repeat (4) @(posedge i_clk);
			for (k = 0; k < i_nb + i_nx; k++) begin
				if (k < i_nb) begin
					o_serial_in <= i_bits[i_nb - 1 - k];
				end else begin
					o_serial_in <= ~o_serial_in; // released wire keeps changing
				end
				repeat (4) @(posedge i_clk);
				o_sclk <= 1'b1;
				if (k >= i_nb) begin
					o_rx <= {o_rx[30:0], i_do};
					o_fl <= {o_fl[30:0], i_flag};
				end
				repeat (4) @(posedge i_clk);
				o_sclk <= 1'b0;
			end
			repeat (4) @(posedge i_clk);
			o_cs_b <= 1'b1; // select held low all frame, new fall per frame
			repeat (4) @(posedge i_clk);
			o_busy <= 1'b0;
		end
	end
endmodule

// ===== tb/tb_serial_adc_conversion_sequencer.sv
// Purpose: self-checking bench of the converter sequencer
// Assumes: serial clock eight master cycles per period
// Notes: comparator answers from a target code: 00 for three frames, FF for three, then random
`timescale 1ns/1ps
module tb_serial_adc_conversion_sequencer;
	logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, pen = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, q, rx, fl, seed = 32'hB564;
	logic pready, pslverr, e, cs_b, sclk, serial_in, shift_en = 1'b0, cmp = 1'b0, dout, oe, flag, com, busy, go = 1'b0;
	logic [7:0] dac, t = 8'h0;
	logic [2:0] chp, chn, lz;
	logic [1:0] v;
	logic [3:0] w;
	logic [15:0] bits = 16'h0;
	logic [4:0] nb = 5'h0, nx = 5'h0, nxv;
	int n_fail = 0, comparisons = 0, f, nw;
	sadcs_top dut_u (.I_MCLK(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwrite),
		.I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
		.I_CS_B(cs_b), .I_SCLK(sclk), .I_SERIAL_IN_LINE(serial_in), .I_LSB_FIRST_SHIFT_ENABLE(shift_en), .I_CMP_HI(cmp),
		.O_DO(dout), .O_DO_OE(oe), .O_CONVERSION_ACTIVE_FLAG(flag), .O_DAC_CODE(dac), .O_CH_POS(chp),
		.O_CH_NEG(chn), .O_NEG_IS_COM(com));
	// a floating output reads as the inverse of its last value, so a late drive shows up
	sadcs_host host_u (.i_clk(clk), .i_go(go), .i_bits(bits), .i_nb(nb), .i_nx(nx), .i_do(oe ? dout : ~dout),
		.i_flag(flag), .o_cs_b(cs_b), .o_sclk(sclk), .o_serial_in(serial_in), .o_busy(busy), .o_rx(rx), .o_fl(fl));
	// 125 MHz master clock
	always #4 clk = ~clk;
	// comparator: analog above trial code
	always @(posedge clk) begin
		cmp <= (t > dac);
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] sar(input logic [7:0] a);
		logic [7:0] r;
		r = 8'h0;
		for (int i = 7; i >= 0; i--) if (a > (r | (8'h01 << i))) r |= 8'h01 << i;
		return r;
	endfunction
	// leading zero, MSB first, then LSB first repeat, held LSB or tail zeros
	function automatic logic [17:0] exp_do(input logic [7:0] r, input logic [1:0] vv, input logic s);
		logic [17:0] x;
		x = 18'h0;
		for (int i = 0; i < 8; i++) x[16 - i] = r[7 - i];
		for (int i = 1; i < 10; i++) begin
			if (vv == sadcs_pkg::VAR_EIGHT && s) x[9 - i] = r[0];
			else if (i < 8 && vv != sadcs_pkg::VAR_ONE) x[9 - i] = r[i];
		end
		return x;
	endfunction
	function automatic logic [2:0] pos_of(input logic [1:0] vv, input logic [3:0] ww);
		if (vv == sadcs_pkg::VAR_EIGHT) return {ww[1:0], ww[2]};
		if (vv == sadcs_pkg::VAR_FOUR) return {1'b0, ww[0], ww[1]};
		return 3'h0;
	endfunction
	// negative input and common flag, {com, neg}
	function automatic logic [3:0] neg_of(input logic [1:0] vv, input logic [3:0] ww);
		if (vv == sadcs_pkg::VAR_EIGHT) return ww[3] ? 4'h8 : {1'b0, ww[1:0], ~ww[2]};
		if (vv == sadcs_pkg::VAR_FOUR) return ww[2] ? 4'h8 : {2'b00, ww[0], ~ww[1]};
		return 4'h1;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] ex);
		comparisons++;
		if (got !== ex) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, ex);
		end
	endtask
	// one APB transfer, waits for ready
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		if (n >= 50) n_fail++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task automatic finish_test;
		$display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// watchdog
	initial begin
		repeat (60000) @(posedge clk);
		n_fail++;
		finish_test;
	end
	// main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		apb(1'b0, sadcs_pkg::OFS_CTRL, 32'h0);
		chk(q, {30'h0, sadcs_pkg::CTRL_RST});
		apb(1'b0, 12'h010, 32'h0);
		chk({q[30:0], e}, 32'h1);
		apb(1'b1, sadcs_pkg::OFS_STATUS, 32'hFFFFFFFF);
		apb(1'b0, sadcs_pkg::OFS_STATUS, 32'h0);
		chk(q, 32'h0);
		for (f = 0; f < 15; f++) begin
			v = 2'(f % 3);
			nw = (v == sadcs_pkg::VAR_ONE) ? 0 : (v == sadcs_pkg::VAR_FOUR) ? 3 : 4;
			w = 4'(rnd()) & 4'((1 << nw) - 1);
			t = (f < 3) ? 8'h00 : (f < 6) ? 8'hFF : 8'(rnd());
			lz = 3'(rnd() % 4);
			nxv = (f % 4 == 3) ? 5'(4 + rnd() % 8) : 5'd18;
			// unused variant code 3 once, expected to act as four channels
			apb(1'b1, sadcs_pkg::OFS_CTRL, {30'h0, (f == 13) ? 2'h3 : v});
			shift_en <= (v == sadcs_pkg::VAR_EIGHT) && (f == 14 || (f > 8 && rnd() % 2 == 1));
			bits <= 16'((1 << nw) | w);
			nb <= 5'(lz + 1 + nw);
			nx <= nxv;
			go <= 1'b1;
			while (flag !== 1'b1) @(posedge clk);
			go <= 1'b0;
			chk({29'h0, chp}, {29'h0, pos_of(v, w)});
			if (v == sadcs_pkg::VAR_EIGHT) chk({31'h0, com}, {31'h0, w[3]});
			chk({28'h0, com, chn}, {28'h0, neg_of(v, w)});
			chk({24'h0, dac}, {24'h0, sadcs_pkg::SAR_TOP});
			// address word is readable only while the frame is still selected
			apb(1'b0, sadcs_pkg::OFS_MUX, 32'h0);
			chk(q, {28'h0, w});
			while (busy !== 1'b0) @(posedge clk);
			chk(rx, 32'(exp_do(sar(t), v, shift_en) >> (18 - nxv)));
			chk(fl, 32'(18'h3FE00 >> (18 - nxv)));
			chk({30'h0, oe, flag}, 32'h0);
			if (nxv == 5'd18) begin
				apb(1'b0, sadcs_pkg::OFS_RESULT, 32'h0);
				chk(q, {24'h0, sar(t)});
			end
			if (nw != 0) begin
				apb(1'b0, sadcs_pkg::OFS_MUX, 32'h0);
				chk(q, 32'h0);
			end
		end
		finish_test;
	end
endmodule
